// File: common/ssn_defines.svh
// Constants of the serial NAND command engine
`ifndef SSN_DEFINES_SVH
`define SSN_DEFINES_SVH

// ----------------------------------------------------------------------
// Opcode field of the command byte
// ----------------------------------------------------------------------
`define SSN_OP_STATUS  4'h0
`define SSN_OP_SETADDR 4'h1
`define SSN_OP_INC     4'h2
`define SSN_OP_READ    4'h3
`define SSN_OP_WRITE   4'h4
`define SSN_OP_ERASE   4'h5
`define SSN_OP_SHIN    4'h6
`define SSN_OP_SHOUT   4'h7
`define SSN_OP_RDLAST  4'ha
`define SSN_OP_WEN     4'hc
`define SSN_OP_WDIS    4'hd
`define SSN_OP_WRLAST  4'he

// ----------------------------------------------------------------------
// Framing, codes and geometry
// ----------------------------------------------------------------------
`define SSN_RSV_ZERO   3'h0
`define SSN_BIT_LAST   3'h7
`define SSN_BIT_START  3'h1
`define SSN_SEC_CODE   8'h55
`define SSN_CNT_ZERO   8'h00
`define SSN_STAT_CNT   8'h07
`define SSN_LARGE      1'b0
`define SSN_LAST_BLK_S 8'h7f
`define SSN_LAST_BLK_L 8'hfe
`define SSN_ADDR_ONE   15'h0001
`define SSN_PAGE_ZERO  8'h00
`define SSN_DREG_W     256
`define SSN_SYNC_W     3

// Status byte bit positions
`define SSN_ST_BUSY    7
`define SSN_ST_PASS    6
`define SSN_ST_WEL     5
`define SSN_ST_SIZE    0

`endif

// File: common/ssn_pkg.sv
// Types of the serial NAND command engine
package ssn_pkg;

  // Parser states
  typedef enum logic [2:0] {
    ST_HUNT   = 3'b000,
    ST_CMD    = 3'b001,
    ST_ARG1   = 3'b010,
    ST_ARG2   = 3'b011,
    ST_SHIN   = 3'b100,
    ST_SHOUT  = 3'b101,
    ST_STAT   = 3'b110,
    ST_IGNORE = 3'b111
  } ssn_state_t;

  // Array sequencer phases
  typedef enum logic [1:0] {
    AP_IDLE = 2'b00,
    AP_PRE  = 2'b01,
    AP_RUN  = 2'b10
  } ssn_aph_t;

  // Array operations
  typedef enum logic [1:0] {
    AOP_READ  = 2'b00,
    AOP_PROG  = 2'b01,
    AOP_ERASE = 2'b10
  } ssn_aop_t;

  // Request to the array
  typedef struct packed {
    ssn_aop_t   op;
    logic [7:0] block;
    logic [7:0] page;
  } ssn_areq_t;

  // Synchronised pins
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic din;
  } ssn_pins_t;

endpackage : ssn_pkg

// File: rtl/ssn_sync.sv
// Two-flop synchronisers for the serial pins
`timescale 1ns/1ps
`default_nettype none
`include "ssn_defines.svh"

module ssn_sync (
  input  wire logic                   clk,    // System clock
  input  wire logic                   resetn, // Async reset, active low
  input  wire logic [`SSN_SYNC_W-1:0] async_i, // Pins from outside
  output logic      [`SSN_SYNC_W-1:0] sync_o   // Synchronised pins
);
  import ssn_pkg::*;

  logic [`SSN_SYNC_W-1:0] meta_q;

  // ----------------------------------------------------------------------
  // One pair of flops per pin; reset value is idle-high
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `SSN_SYNC_W; gi++) begin : g_bit
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          meta_q[gi] <= 1'b1;
          sync_o[gi] <= 1'b1;
        end else begin
          meta_q[gi] <= async_i[gi];
          sync_o[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

endmodule : ssn_sync
`default_nettype wire

// File: rtl/ssn_dreg.sv
// 32-byte data register with shift and parallel load
`timescale 1ns/1ps
`default_nettype none
`include "ssn_defines.svh"

module ssn_dreg (
  input  wire logic                   clk,       // System clock
  input  wire logic                   resetn,    // Async reset, active low
  input  wire logic                   load_en,   // Parallel load strobe
  input  wire logic [`SSN_DREG_W-1:0] load_val,  // Page from array
  input  wire logic                   shift_en,  // Shift one bit in at LSB
  input  wire logic                   shift_bit, // Bit entering LSB
  output logic      [`SSN_DREG_W-1:0] data       // Register contents
);
  import ssn_pkg::*;

  // ----------------------------------------------------------------------
  // Storage; load wins since shifts are refused while busy anyway
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      data <= '0;
    end else if (load_en) begin
      data <= load_val;
    end else if (shift_en) begin
      data <= {data[`SSN_DREG_W-2:0], shift_bit};
    end
  end

endmodule : ssn_dreg
`default_nettype wire

// File: rtl/ssn_engine.sv
// Command engine of the serial NAND memory: parser, address, array sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ssn_defines.svh"

module ssn_engine (
  input  wire logic                   clk,           // System clock, 40 MHz
  input  wire logic                   resetn,        // Async reset, active low
  input  wire logic                   cs_n,          // Chip select pin, active low
  input  wire logic                   serial_clock,  // Serial clock pin
  input  wire logic                   serial_in,     // Serial data in pin
  output logic                        serial_out,    // Serial data out pin
  output logic                        serial_out_oe, // High while driving serial_out
  output logic                        array_req,     // One-cycle array request
  output var ssn_pkg::ssn_areq_t      array_cmd,     // Array op and address
  output logic      [`SSN_DREG_W-1:0] array_wdata,   // Merged page to program
  input  wire logic [`SSN_DREG_W-1:0] array_rdata,   // Page read from array
  input  wire logic                   array_done,    // Array op finished, pulse
  input  wire logic                   array_fail,    // Qualifies done: op failed
  output logic                        busy,          // Array operation running
  output logic                        write_enabled  // Write-enable latch
);
  import ssn_pkg::*;

  ssn_state_t             st_q, st_d, cmd_next, a1_next;
  ssn_aph_t               aph_q;
  ssn_areq_t              areq_q;
  ssn_pins_t              p;
  logic [`SSN_SYNC_W-1:0] pin_s;
  logic [`SSN_DREG_W-1:0] dreg, wdata_q;
  logic [7:0]             sh_q, cnt_q, arg1_q, blk_q, pg_q, stat_sh_q;
  logic [3:0]             cmd_q;
  logic [2:0]             bcnt_q;
  logic                   sck_q, cs_q, so_q, oe_q, req_q, busy_q, wel_q, pass_q;

  // ----------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------------
  ssn_sync u_sync (
    .clk     (clk),
    .resetn  (resetn),
    .async_i ({cs_n, serial_clock, serial_in}),
    .sync_o  (pin_s)
  );
  assign p = pin_s;

  // Edges seen on synchronised copies; SK ignored while deselected
  wire sck_rise = p.sck & ~sck_q & ~p.cs_n;
  wire sck_fall = ~p.sck & sck_q & ~p.cs_n;
  wire cs_rise  = p.cs_n & ~cs_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sck_q <= 1'b1;
      cs_q  <= 1'b1;
    end else begin
      sck_q <= p.sck;
      cs_q  <= p.cs_n;
    end
  end

  // ----------------------------------------------------------------------
  // Byte assembly and command decode
  // ----------------------------------------------------------------------
  wire       in_byte   = (st_q == ST_CMD) | (st_q == ST_ARG1) | (st_q == ST_ARG2);
  wire [7:0] new_byte  = {sh_q[6:0], p.din};
  wire       byte_done = sck_rise & in_byte & (bcnt_q == `SSN_BIT_LAST);
  wire [3:0] opc       = new_byte[6:3];
  wire       rsv_ok    = (new_byte[2:0] == `SSN_RSV_ZERO);
  wire       sec_ok    = (new_byte == `SSN_SEC_CODE);
  wire       cmd_done  = byte_done & (st_q == ST_CMD);
  wire       a1_done   = byte_done & (st_q == ST_ARG1);
  wire       a2_done   = byte_done & (st_q == ST_ARG2);
  wire       cmd_ok    = cmd_done & rsv_ok;
  wire       arg_cmd   = opc inside {`SSN_OP_SETADDR, `SSN_OP_WRITE, `SSN_OP_ERASE,
                                     `SSN_OP_SHIN, `SSN_OP_SHOUT, `SSN_OP_WRLAST};
  wire       imm_cmd   = opc inside {`SSN_OP_INC, `SSN_OP_READ, `SSN_OP_RDLAST};

  // Execute strobes; write-latch commands bypass the busy check
  wire do_wen    = cmd_ok & (opc == `SSN_OP_WEN);
  wire do_wdis   = cmd_ok & (opc == `SSN_OP_WDIS);
  wire do_stat   = cmd_ok & (opc == `SSN_OP_STATUS);
  wire do_inc    = cmd_ok & ~busy_q & (opc == `SSN_OP_INC);
  wire do_read   = cmd_ok & ~busy_q & ((opc == `SSN_OP_READ) | (opc == `SSN_OP_RDLAST));
  wire do_setad  = a2_done & (cmd_q == `SSN_OP_SETADDR);
  wire prog_try  = a1_done & sec_ok &
                   ((cmd_q == `SSN_OP_WRITE) | (cmd_q == `SSN_OP_WRLAST));
  wire do_prog   = prog_try & wel_q;
  wire erase_try = a2_done & sec_ok & (cmd_q == `SSN_OP_ERASE) & wel_q;
  wire [7:0] last_blk = `SSN_LARGE ? `SSN_LAST_BLK_L : `SSN_LAST_BLK_S;
  wire erase_bad = erase_try & (arg1_q >= last_blk); // Last block never erased
  wire do_erase  = erase_try & ~erase_bad;
  wire do_shcnt  = a1_done & ((cmd_q == `SSN_OP_SHIN) | (cmd_q == `SSN_OP_SHOUT));

  // Next state after a command byte and after the first argument
  assign cmd_next = !rsv_ok                ? ST_IGNORE :
                    (opc == `SSN_OP_STATUS) ? ST_STAT   :
                    (do_wen | do_wdis)      ? ST_HUNT   :
                    busy_q                  ? ST_IGNORE :
                    arg_cmd                 ? ST_ARG1   :
                    imm_cmd                 ? ST_HUNT   : ST_IGNORE;
  assign a1_next  = ((cmd_q == `SSN_OP_SETADDR) | (cmd_q == `SSN_OP_ERASE)) ? ST_ARG2 :
                    (cmd_q == `SSN_OP_SHIN)  ? ST_SHIN  :
                    (cmd_q == `SSN_OP_SHOUT) ? ST_SHOUT : ST_HUNT;

  // Parser state; chip select high forces the hunt for a start bit
  always_comb begin
    st_d = st_q;
    if (cs_rise | p.cs_n) begin
      st_d = ST_HUNT;
    end else if (sck_rise) begin
      unique case (st_q)
        ST_HUNT:   if (p.din) st_d = ST_CMD;
        ST_CMD:    if (byte_done) st_d = cmd_next;
        ST_ARG1:   if (byte_done) st_d = a1_next;
        ST_ARG2:   if (byte_done) st_d = ST_HUNT;
        ST_SHIN,
        ST_SHOUT,
        ST_STAT:   if (cnt_q == `SSN_CNT_ZERO) st_d = ST_HUNT;
        ST_IGNORE: st_d = ST_IGNORE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) st_q <= ST_HUNT;
    else         st_q <= st_d;
  end

  // Bit counter and byte shifter; start bit counts as first bit
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bcnt_q <= 3'h0;
      sh_q   <= 8'h00;
    end else if (sck_rise & (st_q == ST_HUNT)) begin
      bcnt_q <= `SSN_BIT_START;
      sh_q   <= {7'h00, p.din};
    end else if (sck_rise & in_byte) begin
      bcnt_q <= bcnt_q + 3'h1;
      sh_q   <= new_byte;
    end
  end

  // Opcode and first argument hold for the rest of the command
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmd_q  <= 4'h0;
      arg1_q <= 8'h00;
    end else begin
      if (cmd_done) cmd_q <= opc;
      if (a1_done) arg1_q <= new_byte;
    end
  end

  // ----------------------------------------------------------------------
  // Bit counts for shift-in, shift-out and status
  // ----------------------------------------------------------------------
  wire sh_state = (st_q == ST_SHIN) | (st_q == ST_SHOUT) | (st_q == ST_STAT);
  wire out_st   = (st_q == ST_SHOUT) | (st_q == ST_STAT);
  wire [7:0] status = {busy_q, pass_q, wel_q, 4'h0, `SSN_LARGE};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 8'h00;
    end else if (do_shcnt) begin
      cnt_q <= new_byte;
    end else if (do_stat) begin
      cnt_q <= `SSN_STAT_CNT;
    end else if (sck_rise & sh_state) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end

  // Status byte goes out MSB first on falling edges
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stat_sh_q <= 8'h00;
    end else if (do_stat) begin
      stat_sh_q <= status;
    end else if (sck_fall & (st_q == ST_STAT)) begin
      stat_sh_q <= {stat_sh_q[6:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------------
  // Data register; no shifts reach it while busy, parser refuses them
  // ----------------------------------------------------------------------
  wire dreg_load  = array_done & (aph_q == AP_RUN) & (areq_q.op == AOP_READ);
  wire dreg_shift = (sck_rise & (st_q == ST_SHIN)) |
                    (sck_fall & (st_q == ST_SHOUT));
  // Outgoing MSB re-enters at LSB, so a full pass restores the page
  wire dreg_bit   = (st_q == ST_SHIN) ? p.din : dreg[`SSN_DREG_W-1];

  ssn_dreg u_dreg (
    .clk       (clk),
    .resetn    (resetn),
    .load_en   (dreg_load),
    .load_val  (array_rdata),
    .shift_en  (dreg_shift),
    .shift_bit (dreg_bit),
    .data      (dreg)
  );

  // ----------------------------------------------------------------------
  // Serial output: data while shifting out, ready level otherwise
  // ----------------------------------------------------------------------
  wire so_bit = (st_q == ST_STAT) ? stat_sh_q[7] : dreg[`SSN_DREG_W-1];
  wire so_d   = !out_st  ? ~busy_q :
                sck_fall ? so_bit  : so_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      so_q <= 1'b1;
      oe_q <= 1'b0;
    end else begin
      so_q <= so_d;
      oe_q <= ~p.cs_n;
    end
  end

  // ----------------------------------------------------------------------
  // Address and write-enable latch
  // ----------------------------------------------------------------------
  // Page wraps into the next block; past the last block the value is junk
  wire [14:0] inc_sum = {blk_q, pg_q[6:0]} + `SSN_ADDR_ONE;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      blk_q <= 8'h00;
      pg_q  <= 8'h00;
    end else if (do_setad) begin
      blk_q <= arg1_q;
      pg_q  <= new_byte;
    end else if (do_inc) begin
      blk_q <= inc_sum[14:7];
      pg_q  <= {1'b0, inc_sum[6:0]};
    end
  end

  // Set wins if both ever coincide, never the case by decode
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)      wel_q <= 1'b0;
    else if (do_wen)  wel_q <= 1'b1;
    else if (do_wdis) wel_q <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // Array sequencer; runs on regardless of chip select
  // ----------------------------------------------------------------------
  wire       use_last = cmd_done ? (opc == `SSN_OP_RDLAST) : (cmd_q == `SSN_OP_WRLAST);
  wire [7:0] req_blk  = use_last ? last_blk : blk_q;
  wire [7:0] req_pg   = (use_last & `SSN_LARGE) ? pg_q : {1'b0, pg_q[6:0]};
  wire       start_rd = do_read | do_prog; // Program first reads for the merge

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aph_q  <= AP_IDLE;
      areq_q <= '{op: AOP_READ, block: 8'h00, page: 8'h00};
      req_q  <= 1'b0;
      busy_q <= 1'b0;
      pass_q <= 1'b1;
    end else begin
      req_q <= 1'b0;
      unique case (aph_q)
        AP_IDLE: begin
          if (start_rd) begin
            areq_q <= '{op: AOP_READ, block: req_blk, page: req_pg};
            aph_q  <= do_prog ? AP_PRE : AP_RUN;
            req_q  <= 1'b1;
            busy_q <= 1'b1;
          end else if (do_erase) begin
            areq_q <= '{op: AOP_ERASE, block: arg1_q, page: `SSN_PAGE_ZERO};
            aph_q  <= AP_RUN;
            req_q  <= 1'b1;
            busy_q <= 1'b1;
          end else if (erase_bad) begin
            pass_q <= 1'b0;
          end
        end
        AP_PRE: begin
          if (array_done & array_fail) begin
            aph_q  <= AP_IDLE;
            busy_q <= 1'b0;
            pass_q <= 1'b0;
          end else if (array_done) begin
            areq_q.op <= AOP_PROG;
            aph_q     <= AP_RUN;
            req_q     <= 1'b1;
          end
        end
        AP_RUN: begin
          if (array_done) begin
            aph_q  <= AP_IDLE;
            busy_q <= 1'b0;
            pass_q <= ~array_fail;
          end
        end
        default: aph_q <= AP_IDLE;
      endcase
    end
  end

  // Only cleared bits reach the array, so FFH leaves cells untouched
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wdata_q <= '1;
    end else if (array_done & (aph_q == AP_PRE)) begin
      wdata_q <= dreg & array_rdata;
    end
  end

  assign serial_out    = so_q;
  assign serial_out_oe = oe_q;
  assign array_req     = req_q;
  assign array_cmd     = areq_q;
  assign array_wdata   = wdata_q;
  assign busy          = busy_q;
  assign write_enabled = wel_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_INC_STEP: assert property (
    do_inc |=> {blk_q, pg_q[6:0]} == $past(inc_sum))
    else $error("increment did not advance the page address");
  AST_READ_LOAD: assert property (
    dreg_load |=> dreg == $past(array_rdata))
    else $error("read data not loaded into data register");
  AST_PROG_GATE: assert property (
    prog_try & ~wel_q & ~busy_q |=> ~busy_q & ~req_q)
    else $error("program started with write latch clear");
  AST_WEL_SET: assert property (
    do_wen |=> wel_q & status[`SSN_ST_WEL])
    else $error("write enable did not set latch");
  AST_WEL_CLR: assert property (
    do_wdis |=> ~wel_q)
    else $error("write disable did not clear latch");
  AST_SHOUT_ROT: assert property (
    sck_fall & (st_q == ST_SHOUT) |=>
      dreg == {$past(dreg[`SSN_DREG_W-2:0]), $past(dreg[`SSN_DREG_W-1])})
    else $error("shift-out did not recirculate");
  AST_LAST_BLK: assert property (
    do_read & (opc == `SSN_OP_RDLAST) |=> req_q & (array_cmd.block == last_blk))
    else $error("last-block read used wrong block");
  AST_BUSY_HOLD: assert property (
    busy_q & ~array_done |=> busy_q)
    else $error("array operation ended without done");
  AST_DO_BUSY: assert property (
    busy_q & ~out_st ##1 busy_q & ~out_st |-> ~so_q)
    else $error("output not low while busy");
  AST_CS_RESET: assert property (
    cs_rise |=> (st_q == ST_HUNT) & ((dreg == $past(dreg)) | $past(dreg_load)))
    else $error("chip select rise did not reset parser");
  AST_MERGE: assert property (
    array_done & (aph_q == AP_PRE) & ~array_fail |=>
      req_q & (array_cmd.op == AOP_PROG) & (wdata_q == $past(dreg & array_rdata)))
    else $error("program data not merged with page");

  COV_SHOUT: cover property (sck_rise & (st_q == ST_SHOUT) & (cnt_q == `SSN_CNT_ZERO));
  COV_PROG:  cover property (array_done & (aph_q == AP_RUN) & (areq_q.op == AOP_PROG));
  COV_ERASE: cover property (do_erase);
  COV_STAT:  cover property (do_stat & busy_q);

endmodule : ssn_engine
`default_nettype wire

// File: bench/ssn_array_model.sv
// Behavioural page array that answers the command engine's requests
`timescale 1ns/1ps
`default_nettype none
`include "ssn_defines.svh"

module ssn_array_model (
  input  wire logic                   clk,   // System clock
  input  wire logic                   req,   // Request pulse
  input  wire ssn_pkg::ssn_areq_t     cmd,   // Op and address
  input  wire logic [`SSN_DREG_W-1:0] wdata, // Page to program
  output logic      [`SSN_DREG_W-1:0] rdata, // Page read out
  output logic                        done,  // Completion pulse
  output logic                        fail   // Never raised here
);
  import ssn_pkg::*;
  logic [`SSN_DREG_W-1:0] mem [bit [15:0]];
  int                     cnt = 0;
  initial {done, fail, rdata} = '0;
  // ------------------------------------------------------------
  // Fixed latency; read data toggles outside done so stale data fails
  // ------------------------------------------------------------
  always @(posedge clk) begin
    done <= 1'b0;
    rdata <= ~rdata;
    if (req) cnt <= 6;
    else if (cnt > 1) cnt <= cnt - 1;
    else if (cnt == 1) begin
      cnt <= 0;
      done <= 1'b1;
      // Unwritten cells read erased, programming only clears bits
      if (cmd.op == AOP_READ) rdata <= mem.exists(cmd[15:0]) ? mem[cmd[15:0]] : '1;
      if (cmd.op == AOP_PROG) mem[cmd[15:0]] = wdata & (mem.exists(cmd[15:0]) ?
        mem[cmd[15:0]] : '1);
      if (cmd.op == AOP_ERASE) for (int p = 0; p < 256; p++) mem.delete({cmd.block, p[7:0]});
    end
  end
endmodule : ssn_array_model
`default_nettype wire

// File: bench/test_ssn_engine.sv
// Self-checking bench of the serial NAND command engine
`timescale 1ns/1ps
`default_nettype none
`include "ssn_defines.svh"

module test_ssn_engine;
  import ssn_pkg::*;
  logic            clk = 0, resetn = 0, cs_n = 1, sclk = 1, sin = 0;
  logic            sout, oe, req, done, fail, busy, wel;
  ssn_areq_t       cmd;
  logic [255:0]    wd, rd, pg;
  logic [7:0]      got;
  logic [7:0]      expq [$];
  int              n_fail = 0, n_compared = 0;
  int unsigned     seed = 13496;
  event            got_e;
  always #12.5 clk = ~clk;
  ssn_engine uut (.clk(clk), .resetn(resetn), .cs_n(cs_n), .serial_clock(sclk),
    .serial_in(sin), .serial_out(sout), .serial_out_oe(oe), .array_req(req),
    .array_cmd(cmd), .array_wdata(wd), .array_rdata(rd), .array_done(done),
    .array_fail(fail), .busy(busy), .write_enabled(wel));
  ssn_array_model arr (.clk(clk), .req(req), .cmd(cmd), .wdata(wd), .rdata(rd),
    .done(done), .fail(fail));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  // One serial bit, 8 clocks; output read two clocks after the rise
  task automatic sbit(input logic b, output logic o);
    @(posedge clk) #2 sclk = 0;
    sin = b;
    repeat (4) @(posedge clk);
    #2 sclk = 1;
    repeat (2) @(posedge clk);
    #1 o = sout;
    @(posedge clk) #1;
  endtask : sbit
  task automatic xbyte(input logic [7:0] v, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) sbit(v[i], r[i]);
  endtask : xbyte
  task automatic tx(input logic [7:0] v);
    logic [7:0] r;
    xbyte(v, r);
  endtask : tx
  // Note the expectation first, then clock the byte out
  task automatic rx(input logic [7:0] exp);
    expq.push_back(exp);
    xbyte(8'h00, got);
    -> got_e;
  endtask : rx
  task automatic page_io(input logic out);
    tx(out ? 8'hb8 : 8'hb0);
    tx(8'hff);
    for (int i = 31; i >= 0; i--) if (out) rx(pg[8*i+:8]); else tx(pg[8*i+:8]);
  endtask : page_io
  task automatic wait_idle();
    int k;
    for (k = 0; k < 400 && busy !== 1'b0; k++) @(posedge clk) #1;
    @(posedge clk) #1;
    check({7'h0, busy}, 8'h00);
    check({6'h0, oe, sout}, 8'h03);
  endtask : wait_idle
  // Result watcher: oldest note against each byte seen
  always @(got_e) check(got, expq.pop_front());
  initial begin #1000000; n_fail++; end_sim(); end
  initial begin
    pg = '0;
    repeat (5) @(posedge clk);
    #2 resetn = 1;
    repeat (4) @(posedge clk);
    check({7'h0, wel}, 8'h00);
    #2 cs_n = 0;
    tx(8'h80); rx(8'h40);
    tx(8'he0); tx(8'h80); rx(8'h60);
    for (int i = 0; i < 8; i++) pg[32*i+:32] = xs();
    page_io(0); tx(8'h88); tx(8'h05); tx(8'h7f);
    tx(8'ha0); tx(8'h55); wait_idle();
    tx(8'hb0); tx(8'h07); tx(8'h00);
    tx(8'h98); repeat (3) @(posedge clk);
    check({7'h0, sout}, 8'h00);
    wait_idle(); page_io(1); page_io(1);
    check(cmd.page, 8'h7f);
    tx(8'h90); tx(8'h98); wait_idle();
    check(cmd.block, 8'h06); check(cmd.page, 8'h00);
    tx(8'hd0); wait_idle(); check(cmd.block, `SSN_LAST_BLK_S);
    tx(8'he8); check({7'h0, wel}, 8'h00);
    tx(8'ha0); tx(8'h55); repeat (6) @(posedge clk);
    check({7'h0, busy}, 8'h00);
    tx(8'he0); tx(8'ha8); tx(8'h05); tx(8'h55); wait_idle();
    check({6'h0, cmd.op}, {6'h0, AOP_ERASE});
    tx(8'h88); tx(8'h05); tx(8'h7f); tx(8'h98); wait_idle();
    pg = '1; page_io(1);
    tx(8'hb0); tx(8'h07); tx(8'ha5); tx(8'hf0); tx(8'h55); wait_idle();
    check({6'h0, cmd.op}, {6'h0, AOP_PROG});
    check(cmd.block, `SSN_LAST_BLK_S);
    tx(8'hd0); wait_idle(); pg[7:0] = 8'ha5; page_io(1);
    tx(8'ha8); tx(8'h7f); tx(8'h55); repeat (6) @(posedge clk);
    check({7'h0, busy}, 8'h00);
    tx(8'h0b);
    @(posedge clk) #2 cs_n = 1;
    repeat (12) @(posedge clk);
    check({7'h0, oe}, 8'h00);
    #2 cs_n = 0;
    tx(8'h80); rx(8'h20);
    @(posedge clk) #2 cs_n = 1;
    repeat (20) @(posedge clk);
    end_sim();
  end
endmodule : test_ssn_engine
`default_nettype wire
